// ---- hdl/swi_pkg.sv ----
package swi_pkg;

    // ---------------------------------------------------------------
    // status word layout
    // ---------------------------------------------------------------
    localparam int SR_FP_LSB = 25;
    localparam int SR_FL_LSB = 21;
    localparam int SR_ILC_LSB = 19;
    localparam int SR_S_BIT = 18;
    localparam int SR_L_BIT = 15;
    localparam int SR_RND_LSB = 13;
    localparam int SR_FTE_LSB = 8;
    localparam int SR_T_BIT = 6;
    localparam int SR_M_BIT = 4;
    localparam logic [31:0] SR_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [1:0] ILC_SWI = 2'h1;
    localparam logic [3:0] FL_NEW = 4'h6;
    localparam logic [4:0] FL_ZERO_AS = 5'h10;
    localparam logic [2:0] SAVE_LAST = 3'h4;
    localparam logic [22:0] ENTRY_ONES = 23'h7f_ffff;

    // ---------------------------------------------------------------
    // exception register and not-a-number layout
    // ---------------------------------------------------------------
    localparam int FER_ACC_LSB = 0;
    localparam int FER_ACT_LSB = 8;
    localparam int EXC_OV = 2;
    localparam int EXC_UN = 1;
    localparam int EXC_NX = 0;
    localparam int NAN_EXP_LSB = 19;
    localparam int NAN_EXP_W = 12;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_PC = 8'h04;
    localparam logic [7:0] REG_FP_EXC = 8'h08;
    localparam logic [7:0] REG_LOCAL_IDX = 8'h0c;
    localparam logic [7:0] REG_LOCAL_DATA = 8'h10;
    localparam logic [7:0] REG_ENTRY_STATE = 8'h14;

    typedef enum logic [1:0] {RND_NEAREST, RND_ZERO, RND_MINUS, RND_PLUS} swi_round_type;
    typedef enum {ST_IDLE, ST_SAVE, ST_UPDATE} swi_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } swi_bus_type;

    typedef struct packed {
        logic [3:0] op;
        logic [5:0] src_high_reg;
        logic [31:0] dest_addr;
        logic [31:0] ret_pc;
    } swi_req_type;

    // zero length means a full sixteen-register frame
    function automatic logic [4:0] eff_len(input logic [3:0] fl);
        eff_len = (fl == 4'h0) ? FL_ZERO_AS : {1'b0, fl};
    endfunction

    function automatic logic [31:0] entry_address(input logic [3:0] op);
        entry_address = {ENTRY_ONES, 1'b0, op, 4'h0};
    endfunction

    function automatic swi_round_type round_of(input logic [31:0] sr);
        round_of = swi_round_type'(sr[SR_RND_LSB +: 2]);
    endfunction

endpackage

// ---- hdl/swi_nan_class.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// not-a-number classifier for the exponent-bearing operand word
// ---------------------------------------------------------------
module swi_nan_class (
    input wire logic [31:0] word_i,
    output logic nan_o,
    output logic snan_o
);
    // other bits never matter for nan_o; bit 0 alone decides the signaling class
    assign nan_o = &word_i[swi_pkg::NAN_EXP_LSB +: swi_pkg::NAN_EXP_W];
    assign snan_o = nan_o & word_i[0];
endmodule

// ---- hdl/swi_fp_flags.sv ----
`timescale 1ns/1ps
module swi_fp_flags (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    input wire logic exc_valid_i,
    input wire logic [4:0] exc_i,
    input wire logic [4:0] fte_i,
    output logic [31:0] fer_o,
    output logic trap_o
);
    typedef struct packed {
        logic [4:0] actual;
        logic [4:0] accrued;
        logic trap;
    } swi_fer_type;

    swi_fer_type r_reg;
    swi_fer_type r_next;
    logic [4:0] en;
    logic prio;

    // ---------------------------------------------------------------
    // flag update: an event in the write cycle still lands
    // ---------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.trap = 1'b0;
        en = exc_i & fte_i;
        prio = en[swi_pkg::EXC_OV] | en[swi_pkg::EXC_UN];
        if (prio) begin
            en[swi_pkg::EXC_NX] = 1'b0;
        end
        if (wr_i) begin
            r_next.accrued = wdata_i[swi_pkg::FER_ACC_LSB +: 5];
            r_next.actual = wdata_i[swi_pkg::FER_ACT_LSB +: 5];
        end
        if (exc_valid_i) begin
            r_next.accrued = r_next.accrued | (exc_i & ~fte_i);
            if (prio && exc_i[swi_pkg::EXC_NX]) begin
                r_next.accrued[swi_pkg::EXC_NX] = 1'b1;
            end
            if (|en) begin
                r_next.actual = en;
                r_next.trap = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // reserved bits are never stored, so they cannot read back nonzero
    assign fer_o = {19'h0, r_reg.actual, 3'h0, r_reg.accrued};
    assign trap_o = r_reg.trap;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_actual_only: assert property (exc_valid_i && |(exc_i & fte_i) && !(exc_i[1] | exc_i[2])
        |=> fer_o[12:8] == $past(exc_i & fte_i) && trap_o)
        else $error("actual flags not set to the enabled exception alone");
    a_inexact_prio: assert property (exc_valid_i && exc_i[0] && fte_i[0] && (|(exc_i[2:1] & fte_i[2:1]))
        |=> !fer_o[8] && fer_o[0])
        else $error("overflow or underflow did not take priority over inexact");
    a_reserved_zero: assert property (fer_o[31:13] == 19'h0 && fer_o[7:5] == 3'h0)
        else $error("reserved exception bits nonzero");
    a_disabled_keep: assert property (exc_valid_i && !wr_i && ((exc_i & fte_i) == 5'h0)
        |=> fer_o[12:8] == $past(fer_o[12:8]) && ((fer_o[4:0] & $past(exc_i)) == $past(exc_i)))
        else $error("disabled exception changed actual flags or missed accrued");
endmodule

// ---- hdl/swi_trap_entry.sv ----
`timescale 1ns/1ps
module swi_trap_entry (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire swi_pkg::swi_bus_type bus_i,
    output logic [31:0] bus_rdata_o,
    input wire logic req_valid_i,
    input wire swi_pkg::swi_req_type req_i,
    input wire logic cond_we_i,
    input wire logic [3:0] cond_i,
    input wire logic cond_fp_noncmp_i,
    input wire logic fp_exc_valid_i,
    input wire logic [4:0] fp_exc_i,
    input wire logic [31:0] operand_i,
    output logic busy_o,
    output logic entry_done_o,
    output logic [31:0] pc_o,
    output logic [31:0] status_o,
    output swi_pkg::swi_round_type round_mode_o,
    output logic fp_trap_o,
    output logic operand_nan_o,
    output logic operand_snan_o
);
    typedef struct packed {
        swi_pkg::swi_state_type state;
        logic [2:0] k;
        logic [3:0] op;
        logic [5:0] base;
        logic [31:0] pc;
        logic [31:0] sr;
        logic [4:0][31:0] save;
        logic [5:0] lidx;
        logic [31:0] rdata;
        logic done;
        logic [63:0][31:0] locals;
    } swi_core_type;

    swi_core_type r_reg;
    swi_core_type r_next;
    logic [31:0] fer_rd;
    logic fer_wr;

    // ---------------------------------------------------------------
    // helpers on the status word fields
    // ---------------------------------------------------------------
    function automatic logic [6:0] fp_of(input logic [31:0] sr);
        fp_of = sr[swi_pkg::SR_FP_LSB +: 7];
    endfunction

    function automatic logic [3:0] fl_of(input logic [31:0] sr);
        fl_of = sr[swi_pkg::SR_FL_LSB +: 4];
    endfunction

    // register index of frame slot k; wraps around the 64 locals
    function automatic logic [5:0] slot(input logic [31:0] sr, input logic [5:0] off);
        slot = 6'(fp_of(sr) + 7'(swi_pkg::eff_len(fl_of(sr))) + 7'(off));
    endfunction

    // ---------------------------------------------------------------
    // exception register and operand class
    // ---------------------------------------------------------------
    assign fer_wr = bus_i.wr && (bus_i.addr == swi_pkg::REG_FP_EXC);

    swi_fp_flags u_flags (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .wr_i(fer_wr),
        .wdata_i(bus_i.wdata),
        .exc_valid_i(fp_exc_valid_i),
        .exc_i(fp_exc_i),
        .fte_i(r_reg.sr[swi_pkg::SR_FTE_LSB +: 5]),
        .fer_o(fer_rd),
        .trap_o(fp_trap_o)
    );

    swi_nan_class u_nan (
        .word_i(operand_i),
        .nan_o(operand_nan_o),
        .snan_o(operand_snan_o)
    );

    // ---------------------------------------------------------------
    // next state: bus access, flag updates, entry sequence
    // ---------------------------------------------------------------
    always_comb begin
        logic [5:0] src;
        src = '0;
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.rdata = 32'h0000_0000;

        // bus writes first so the entry sequence below wins on overlap
        if (bus_i.wr) begin
            case (bus_i.addr)
                swi_pkg::REG_STATUS: begin
                    r_next.sr = bus_i.wdata;
                end
                swi_pkg::REG_PC: begin
                    r_next.pc = bus_i.wdata;
                end
                swi_pkg::REG_LOCAL_IDX: begin
                    r_next.lidx = bus_i.wdata[5:0];
                end
                swi_pkg::REG_LOCAL_DATA: begin
                    r_next.locals[r_reg.lidx] = bus_i.wdata;
                end
                default: begin
                end
            endcase
        end

        // read data stand in the cycle after the strobe; unmapped reads zero
        if (bus_i.rd) begin
            case (bus_i.addr)
                swi_pkg::REG_STATUS: r_next.rdata = r_reg.sr;
                swi_pkg::REG_PC: r_next.rdata = r_reg.pc;
                swi_pkg::REG_FP_EXC: r_next.rdata = fer_rd;
                swi_pkg::REG_LOCAL_IDX: r_next.rdata = {26'h0, r_reg.lidx};
                swi_pkg::REG_LOCAL_DATA: r_next.rdata = r_reg.locals[r_reg.lidx];
                swi_pkg::REG_ENTRY_STATE: r_next.rdata = {29'h0, r_reg.k};
                default: r_next.rdata = 32'h0000_0000;
            endcase
        end

        // condition flags: float results other than compares are dropped
        if (cond_we_i && !cond_fp_noncmp_i) begin
            r_next.sr[3:0] = cond_i;
        end

        case (r_reg.state)
            swi_pkg::ST_IDLE: begin
                if (req_valid_i) begin
                    src = 6'(fp_of(r_reg.sr) + 7'(req_i.src_high_reg));
                    // operands are copied now, before any slot is written,
                    // so a source aliasing a frame slot still saves its old value
                    r_next.save[0] = req_i.dest_addr;
                    r_next.save[1] = r_reg.locals[src];
                    r_next.save[2] = r_reg.locals[6'(src + 6'h1)];
                    r_next.save[3] = {req_i.ret_pc[31:1], r_reg.sr[swi_pkg::SR_S_BIT]};
                    r_next.save[4] = r_reg.sr;
                    r_next.save[4][swi_pkg::SR_ILC_LSB +: 2] = swi_pkg::ILC_SWI;
                    r_next.base = slot(r_reg.sr, 6'h0);
                    r_next.op = req_i.op;
                    r_next.k = 3'h0;
                    r_next.state = swi_pkg::ST_SAVE;
                end
            end
            swi_pkg::ST_SAVE: begin
                // one local write per cycle, ascending from the frame base
                r_next.locals[6'(r_reg.base + 6'(r_reg.k))] = r_reg.save[r_reg.k];
                if (r_reg.k == swi_pkg::SAVE_LAST) begin
                    r_next.state = swi_pkg::ST_UPDATE;
                end else begin
                    r_next.k = 3'(r_reg.k + 3'h1);
                end
            end
            swi_pkg::ST_UPDATE: begin
                r_next.sr[swi_pkg::SR_FP_LSB +: 7] =
                    7'(fp_of(r_reg.sr) + 7'(swi_pkg::eff_len(fl_of(r_reg.sr))));
                r_next.sr[swi_pkg::SR_FL_LSB +: 4] = swi_pkg::FL_NEW;
                r_next.sr[swi_pkg::SR_M_BIT] = 1'b0;
                r_next.sr[swi_pkg::SR_T_BIT] = 1'b0;
                r_next.sr[swi_pkg::SR_L_BIT] = 1'b1;
                r_next.sr[3:0] = r_reg.sr[3:0];
                r_next.pc = swi_pkg::entry_address(r_reg.op);
                r_next.done = 1'b1;
                r_next.k = 3'h0;
                r_next.state = swi_pkg::ST_IDLE;
            end
            default: begin
                r_next.state = swi_pkg::ST_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= '0;
            r_reg.state <= swi_pkg::ST_IDLE;
            r_reg.sr <= swi_pkg::SR_RESET;
            r_reg.pc <= swi_pkg::PC_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // busy decodes the registered state, so the core sees it in the accept cycle's successor
    assign busy_o = (r_reg.state != swi_pkg::ST_IDLE);
    assign entry_done_o = r_reg.done;
    assign pc_o = r_reg.pc;
    assign status_o = r_reg.sr;
    assign bus_rdata_o = r_reg.rdata;
    assign round_mode_o = swi_pkg::round_of(r_reg.sr);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_accept;
        r_reg.state == swi_pkg::ST_IDLE && req_valid_i;
    endsequence

    sequence s_saving;
        busy_o && !entry_done_o;
    endsequence

    a_entry_pc: assert property (s_accept |-> ##7 entry_done_o &&
        pc_o == {23'h7f_ffff, 1'b0, $past(req_i.op, 7), 4'h0})
        else $error("entry address wrong or late");
    a_busy_window: assert property (s_accept |=> s_saving [*6] ##1 (!busy_o && entry_done_o))
        else $error("entry sequence not six busy cycles");
    a_frame_base: assert property (s_accept |=> r_reg.base ==
        6'($past(r_reg.sr[31:25]) + (($past(r_reg.sr[24:21]) == 4'h0) ? 7'h10 : 7'($past(r_reg.sr[24:21])))))
        else $error("frame base wrong");
    a_save_write: assert property (r_reg.state == swi_pkg::ST_SAVE |=>
        r_reg.locals[$past(6'(r_reg.base + 6'(r_reg.k)))] == $past(r_reg.save[r_reg.k]))
        else $error("saved word not written to its slot");
    a_ilc_saved: assert property (s_accept |=> r_reg.save[4][20:19] == 2'h1 &&
        r_reg.save[3][0] == $past(r_reg.sr[18]))
        else $error("saved status or return word malformed");
    a_frame_grow: assert property (s_accept |-> ##7 status_o[24:21] == 4'h6 &&
        status_o[31:25] == 7'($past(r_reg.sr[31:25], 7) + 7'(swi_pkg::eff_len($past(r_reg.sr[24:21], 7)))))
        else $error("frame pointer or length not updated");
    a_entry_flags: assert property (entry_done_o |-> status_o[15] && !status_o[6] && !status_o[4] &&
        status_o[3:0] == $past(status_o[3:0]))
        else $error("mode flags wrong after entry");
    a_alias_snap: assert property (s_accept |=>
        r_reg.save[1] == $past(r_reg.locals[6'(r_reg.sr[30:25] + req_i.src_high_reg)]))
        else $error("source high word not snapshotted");
    a_fp_keep_cond: assert property (cond_we_i && cond_fp_noncmp_i &&
        !(bus_i.wr && bus_i.addr == swi_pkg::REG_STATUS) |=> status_o[3:0] == $past(status_o[3:0]))
        else $error("float instruction changed condition flags");
    a_round_map: assert property (status_o[14:13] == 2'h3 |-> round_mode_o == swi_pkg::RND_PLUS)
        else $error("rounding select decoded wrongly");
    a_read_late: assert property (bus_i.rd && bus_i.addr == swi_pkg::REG_FP_EXC |=>
        bus_rdata_o == $past(fer_rd))
        else $error("exception register read mismatch");

    // ---------------------------------------------------------------
    // snapshot, refusal and decode checks
    // ---------------------------------------------------------------
    // every snapshot word is fixed at accept, before any slot write
    a_dest_saved: assert property (s_accept |=> r_reg.save[0] == $past(req_i.dest_addr))
        else $error("destination stack address not snapshotted");
    a_alias_low: assert property (s_accept |=>
        r_reg.save[2] == $past(r_reg.locals[6'(r_reg.sr[30:25] + req_i.src_high_reg + 6'h1)]))
        else $error("source low word not snapshotted");
    a_status_saved: assert property (s_accept |=> r_reg.save[4][31:21] == $past(r_reg.sr[31:21]) &&
        r_reg.save[4][18:0] == $past(r_reg.sr[18:0]))
        else $error("saved status altered beyond its length code");

    // slots go out strictly in ascending order, one per cycle
    a_save_ascend: assert property (r_reg.state == swi_pkg::ST_SAVE && r_reg.k != swi_pkg::SAVE_LAST |=>
        r_reg.k == 3'($past(r_reg.k) + 3'h1))
        else $error("save step did not advance by one");

    // a refused request must leave the captured entry untouched
    a_refuse_busy: assert property (busy_o && req_valid_i |=> r_reg.op == $past(r_reg.op) &&
        r_reg.base == $past(r_reg.base))
        else $error("request taken while an entry was in progress");
    a_done_pulse: assert property (entry_done_o |=> !entry_done_o)
        else $error("entry done longer than one cycle");
    a_step_reset: assert property (entry_done_o |-> r_reg.k == 3'h0)
        else $error("entry step not back at zero when done");

    // the new program counter may only appear together with done
    a_pc_hold: assert property (busy_o && !(bus_i.wr && bus_i.addr == swi_pkg::REG_PC) |=>
        entry_done_o || pc_o == $past(pc_o))
        else $error("program counter moved before the entry finished");

    // enables come from the live status word, not a stale copy
    a_trap_enable: assert property (fp_exc_valid_i && |(fp_exc_i & status_o[12:8]) |=> fp_trap_o)
        else $error("enabled float exception raised no trap");
    a_round_near: assert property (status_o[14:13] == 2'h0 |-> round_mode_o == swi_pkg::RND_NEAREST)
        else $error("nearest rounding decoded wrongly");
    a_round_zero: assert property (status_o[14:13] == 2'h1 |-> round_mode_o == swi_pkg::RND_ZERO)
        else $error("toward zero rounding decoded wrongly");
    a_round_minus: assert property (status_o[14:13] == 2'h2 |-> round_mode_o == swi_pkg::RND_MINUS)
        else $error("toward minus rounding decoded wrongly");
endmodule

// ---- hdl/dummy_removed.sv ----
`timescale 1ns/1ps

// ---- testbench/swi_trap_entry_tb.sv ----
`timescale 1ns/1ps
module testbench;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    swi_pkg::swi_bus_type bus_i = '0;
    logic [31:0] bus_rdata_o;
    logic req_valid_i = 1'b0;
    swi_pkg::swi_req_type req_i = '0;
    logic cond_we_i = 1'b0;
    logic [3:0] cond_i = 4'h0;
    logic cond_fp_noncmp_i = 1'b0;
    logic fp_exc_valid_i = 1'b0;
    logic [4:0] fp_exc_i = 5'h00;
    logic [31:0] operand_i = 32'h0;
    logic busy_o, entry_done_o, fp_trap_o, operand_nan_o, operand_snan_o;
    logic [31:0] pc_o, status_o, rd, fer_model;
    swi_pkg::swi_round_type round_mode_o;
    logic [4:0] en, exc;
    logic [3:0] c;
    int mismatches = 0;
    int comparisons = 0;

    swi_trap_entry u_swi_trap_entry (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus_i),
        .bus_rdata_o(bus_rdata_o), .req_valid_i(req_valid_i), .req_i(req_i), .cond_we_i(cond_we_i),
        .cond_i(cond_i), .cond_fp_noncmp_i(cond_fp_noncmp_i), .fp_exc_valid_i(fp_exc_valid_i),
        .fp_exc_i(fp_exc_i), .operand_i(operand_i), .busy_o(busy_o), .entry_done_o(entry_done_o),
        .pc_o(pc_o), .status_o(status_o), .round_mode_o(round_mode_o), .fp_trap_o(fp_trap_o),
        .operand_nan_o(operand_nan_o), .operand_snan_o(operand_snan_o));

    // 50 MHz core clock
    always #10 sys_clk_i = ~sys_clk_i;

    // ---------------------------------------------------------------
    // compare, bus and closing tasks
    // ---------------------------------------------------------------
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    // strobe is released on the edge that samples it, so calls never collide
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk_i);
        bus_i <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk_i);
        bus_i <= '0;
        #1 d = bus_rdata_o;
    endtask

    task automatic results;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // expectation helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] fer_next(input logic [31:0] f, input logic [4:0] x, input logic [4:0] e);
        logic [4:0] acc, act, t;
        acc = f[4:0] | (x & ~e);
        act = f[12:8];
        t = x & e;
        // an enabled overflow or underflow outranks inexact
        if (t[2] | t[1]) begin
            t[0] = 1'b0;
            acc[0] = acc[0] | x[0];
        end
        if (t != 5'h00) begin
            act = t;
        end
        return {19'h0, act, 3'h0, acc};
    endfunction

    // one entry: frame set up over the bus, request, then walk of the seven cycles
    task automatic run_entry(input logic [6:0] fp, input logic [3:0] fl, input logic alias_src);
        logic [31:0] sr, hi, lo, exp_sr, got;
        logic [31:0] slot [5];
        logic [4:0] el;
        logic [5:0] idx, base;
        swi_pkg::swi_req_type rq;
        el = (fl == 4'h0) ? 5'h10 : {1'b0, fl};
        sr = $urandom;
        sr[31:25] = fp;
        sr[24:21] = fl;
        sr[20:19] = 2'h0;
        sr[15] = 1'b0;
        sr[6] = 1'b1;
        sr[4] = 1'b1;
        rq.op = 4'($urandom);
        rq.src_high_reg = alias_src ? {1'b0, el} : 6'($urandom);
        rq.dest_addr = $urandom;
        rq.ret_pc = $urandom;
        hi = $urandom;
        lo = $urandom;
        base = 6'(fp + 7'(el));
        idx = 6'(fp + 7'(rq.src_high_reg));
        bus_wr(swi_pkg::REG_STATUS, sr);
        bus_wr(swi_pkg::REG_LOCAL_IDX, {26'h0, idx});
        bus_wr(swi_pkg::REG_LOCAL_DATA, hi);
        bus_wr(swi_pkg::REG_LOCAL_IDX, {26'h0, 6'(idx + 6'h1)});
        bus_wr(swi_pkg::REG_LOCAL_DATA, lo);
        @(posedge sys_clk_i);
        // requests never stand in a delay slot
        req_valid_i <= 1'b1;
        req_i <= rq;
        @(posedge sys_clk_i);
        req_valid_i <= 1'b0;
        for (int k = 1; k <= 7; k++) begin
            @(posedge sys_clk_i);
            // a request while busy must be dropped silently
            if (k == 2) req_valid_i <= 1'b1;
            if (k == 3) req_valid_i <= 1'b0;
            #1;
            check_bit("busy", k < 6, busy_o);
            check_bit("entry_done", k == 6, entry_done_o);
        end
        check_word("pc", {23'h7f_ffff, 1'b0, rq.op, 4'h0}, pc_o);
        exp_sr = sr;
        exp_sr[31:25] = 7'(fp + 7'(el));
        exp_sr[24:21] = 4'h6;
        exp_sr[15] = 1'b1;
        exp_sr[6] = 1'b0;
        exp_sr[4] = 1'b0;
        // the live instruction length code (bits 20:19) is not specified after entry, so it is masked
        check_word("status", exp_sr & 32'hffe7_ffff, status_o & 32'hffe7_ffff);
        @(posedge sys_clk_i);
        #1;
        check_bit("busy_after", 1'b0, busy_o);
        slot[0] = rq.dest_addr;
        slot[1] = hi;
        slot[2] = lo;
        slot[3] = {rq.ret_pc[31:1], sr[18]};
        slot[4] = {sr[31:21], 2'h1, sr[18:0]};
        for (int i = 0; i < 5; i++) begin
            bus_wr(swi_pkg::REG_LOCAL_IDX, {26'h0, 6'(base + 6'(i))});
            bus_rd(swi_pkg::REG_LOCAL_DATA, got);
            check_word("saved_slot", slot[i], got);
        end
        // a dispatch routine steps its saved return past the selector halfword
        bus_wr(swi_pkg::REG_LOCAL_IDX, {26'h0, 6'(base + 6'h3)});
        bus_wr(swi_pkg::REG_LOCAL_DATA, slot[3] + 32'h2);
        bus_rd(swi_pkg::REG_LOCAL_DATA, got);
        check_word("return_advanced", slot[3] + 32'h2, got);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'h2486eaf1));
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        #1;
        check_word("pc_reset", 32'h0, pc_o);
        check_word("status_reset", 32'h0, status_o);
        bus_rd(8'h40, rd);
        check_word("unmapped", 32'h0, rd);
        bus_rd(swi_pkg::REG_ENTRY_STATE, rd);
        check_word("entry_step", 32'h0, rd);
        // corner cases first: zero length, aliased source, then random frames
        run_entry(7'h7c, 4'h0, 1'b0);
        run_entry(7'h21, 4'hf, 1'b1);
        for (int n = 0; n < 3; n++) run_entry(7'($urandom), 4'($urandom), n[0]);
        // float non-compare drops the flag write, an ordinary write lands
        c = ~status_o[3:0];
        for (int m = 0; m < 2; m++) begin
            @(posedge sys_clk_i);
            cond_we_i <= 1'b1;
            cond_i <= c;
            cond_fp_noncmp_i <= (m == 0);
            @(posedge sys_clk_i);
            cond_we_i <= 1'b0;
            @(posedge sys_clk_i);
            #1;
            check_word("cond_flags", (m == 0) ? {28'h0, ~c} : {28'h0, c}, {28'h0, status_o[3:0]});
        end
        for (int i = 0; i < 4; i++) begin
            bus_wr(swi_pkg::REG_STATUS, 32'(i) << 13);
            #1;
            check_word("round_mode", 32'(i), {30'h0, round_mode_o});
        end
        // reserved exception bits never read back as ones
        bus_wr(swi_pkg::REG_FP_EXC, 32'hffff_ffff);
        bus_rd(swi_pkg::REG_FP_EXC, rd);
        check_word("fer_reserved", 32'h0000_1f1f, rd);
        bus_wr(swi_pkg::REG_FP_EXC, 32'h0);
        fer_model = 32'h0;
        for (int i = 0; i < 12; i++) begin
            en = (i == 0) ? 5'h04 : (i == 1) ? 5'h1f : 5'($urandom);
            exc = (i == 0) ? 5'h05 : (i == 1) ? 5'h03 : 5'($urandom);
            bus_wr(swi_pkg::REG_STATUS, {19'h0, en, 8'h0});
            @(posedge sys_clk_i);
            fp_exc_valid_i <= 1'b1;
            fp_exc_i <= exc;
            @(posedge sys_clk_i);
            fp_exc_valid_i <= 1'b0;
            #1;
            check_bit("fp_trap", |(exc & en), fp_trap_o);
            @(posedge sys_clk_i);
            #1;
            check_bit("fp_trap_end", 1'b0, fp_trap_o);
            fer_model = fer_next(fer_model, exc, en);
            bus_rd(swi_pkg::REG_FP_EXC, rd);
            check_word("fer", fer_model, rd);
        end
        for (int i = 0; i < 16; i++) begin
            rd = $urandom;
            if (i[0]) rd[30:19] = 12'hfff;
            if (i == 2) rd[30:19] = 12'hffe;
            @(posedge sys_clk_i);
            operand_i <= rd;
            #1;
            check_bit("nan", &rd[30:19], operand_nan_o);
            check_bit("snan", (&rd[30:19]) & rd[0], operand_snan_o);
        end
        results;
    end

    // watchdog sized well above the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        results;
    end
endmodule
